// ### rtl/pmr_pkg.sv
package pmr_pkg;
  // Register pointers
  localparam logic [2:0] PTR_SETUP = 3'h0;
  localparam logic [2:0] PTR_SHUNT = 3'h1;
  localparam logic [2:0] PTR_RAIL = 3'h2;
  localparam logic [2:0] PTR_POWER = 3'h3;
  localparam logic [2:0] PTR_CURRENT = 3'h4;
  localparam logic [2:0] PTR_SCALE = 3'h5;
  // Reset values
  localparam logic [15:0] SETUP_RST = 16'h399F;
  localparam logic [15:0] ZERO16 = 16'h0000;
  // Setup field positions
  localparam int SOFT_RST_BIT = 15;
  localparam int RAIL_FSR_BIT = 13;
  localparam int GAIN_HI_BIT = 12;
  localparam int GAIN_LO_BIT = 11;
  // Rail result alignment: lowest data bit sits at bit 3
  localparam int RAIL_SHIFT = 3;
  // Current divide by 4096 is a shift by 12
  localparam int CUR_SHIFT = 12;
  // Power divisor
  localparam logic [31:0] PWR_DIV = 32'h0000_1388;
  // Register settle time 4 us at 40 MHz
  localparam int SETTLE_NS = 4000;
  localparam int CLK_NS = 25;
  localparam int SETTLE_CYC = SETTLE_NS / CLK_NS;
  // Arithmetic sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_CUR, ST_PWR} pmr_state_t;
endpackage

// ### rtl/pmr_if.sv
`timescale 1ns/100ps
// Register read port shared between the top and the result store
interface pmr_if;
  logic [2:0] rdPtr;
  logic [15:0] rdData;
  modport store (input rdPtr, output rdData);
  modport user (output rdPtr, input rdData);
endinterface

// ### rtl/pmr_read_mux.sv
`timescale 1ns/100ps
// Registered read mux over the six result and setup words
module pmr_read_mux
  import pmr_pkg::*;
(
  // Clock and control
  input wire logic clk,
  input wire logic ce,
  // Register values
  input wire logic [15:0] setupVal,
  input wire logic [15:0] shuntVal,
  input wire logic [15:0] railVal,
  input wire logic [15:0] powerVal,
  input wire logic [15:0] currentVal,
  input wire logic [15:0] scaleVal,
  // Read port
  pmr_if.store rd
);
  logic [15:0] data_d;
  logic [15:0] data_q;

  // Select word by pointer; unmapped pointers read zero
  always_comb begin
    case (rd.rdPtr)
      PTR_SETUP: data_d = setupVal;
      PTR_SHUNT: data_d = shuntVal;
      PTR_RAIL: data_d = railVal;
      PTR_POWER: data_d = powerVal;
      PTR_CURRENT: data_d = currentVal;
      PTR_SCALE: data_d = scaleVal;
      default: data_d = ZERO16;
    endcase
  end

  // Read data from a register
  always_ff @(posedge clk) begin
    if (ce) begin
      data_q <= data_d;
    end
  end

  assign rd.rdData = data_q;
endmodule // pmr_read_mux

// ### rtl/pmr_regs.sv
`timescale 1ns/100ps
module pmr_regs
  import pmr_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Byte port from the serial engine
  input wire logic [2:0] ptr,
  input wire logic wrByte,
  input wire logic [7:0] wrData,
  input wire logic wrLast,
  input wire logic rdByte,
  output logic [7:0] rdData,
  output logic rdValid,
  // Results from the converter
  input wire logic shuntStb,
  input wire logic [DATA_W-1:0] shuntIn,
  input wire logic railStb,
  input wire logic [DATA_W-1:0] railIn,
  // Setup fields to the front end, plus the busy flag
  output logic railFullScaleSelect,
  output logic [1:0] shuntGainSelect,
  output logic [10:0] convSetup,
  output logic busy
);
  // Register storage
  logic [15:0] setup_q, setup_d;
  logic [15:0] shunt_q, shunt_d;
  logic [15:0] rail_q, rail_d;
  logic [15:0] power_q, power_d;
  logic [15:0] current_q, current_d;
  logic [15:0] scale_q, scale_d;
  // Byte pairing: high byte held until low arrives
  logic [7:0] hiByte_q, hiByte_d;
  logic half_q, half_d;
  // Read side: high then low
  logic rdHalf_q, rdHalf_d;
  logic [7:0] rdData_d;
  logic rdValid_d;
  // Arithmetic sequencer
  pmr_state_t st_q, st_d;
  logic pend_q, pend_d;
  logic busy_d;
  logic softRst;
  logic wordDone;
  logic [15:0] wordVal;
  logic signed [31:0] curProd;
  logic signed [31:0] pwrProd;
  logic [12:0] railAligned;

  pmr_if rdp();
  assign rdp.rdPtr = ptr;

  // Registered read mux
  pmr_read_mux u_mux (
    .clk(clk),
    .ce(ce),
    .setupVal(setup_q),
    .shuntVal(shunt_q),
    .railVal(rail_q),
    .powerVal(power_q),
    .currentVal(current_q),
    .scaleVal(scale_q),
    .rd(rdp.store)
  );

  // Two's complement saturate-free truncation to 16 bits
  function automatic logic [15:0] trunc16(input logic signed [31:0] v);
    trunc16 = v[15:0];
  endfunction

  assign wordDone = wrByte & half_q & wrLast;
  assign wordVal = {hiByte_q, wrData};
  // Reset bit travels in the high byte; the low byte must not mask it
  assign softRst = wordDone & (ptr == PTR_SETUP) & wordVal[SOFT_RST_BIT];
  assign railAligned = rail_q[15:RAIL_SHIFT];
  // Signed shunt times scale; divide by shifting keeps sign
  // Whole 16-bit scale, zero-extended so a high scale never flips the sign
  assign curProd = $signed(shunt_q) * $signed({1'b0, scale_q}) >>> CUR_SHIFT;
  // Power from current magnitude times rail counts over the divisor
  assign pwrProd = $signed(32'(current_q[15] ? -$signed(current_q) : $signed(current_q)))
                   * $signed({19'h00000, railAligned}) / $signed(PWR_DIV);

  // Next-state logic for the whole bank
  always_comb begin
    setup_d = setup_q;
    shunt_d = shunt_q;
    rail_d = rail_q;
    power_d = power_q;
    current_d = current_q;
    scale_d = scale_q;
    hiByte_d = hiByte_q;
    half_d = half_q;
    rdHalf_d = rdHalf_q;
    rdData_d = rdData;
    rdValid_d = 1'b0;
    st_d = st_q;
    pend_d = pend_q;
    busy_d = 1'b0;
    // Write bytes pair high first
    if (wrByte) begin
      if (!half_q) begin
        hiByte_d = wrData;
        half_d = 1'b1;
      end else begin
        half_d = 1'b0;
      end
    end
    // Read bytes: high then low
    if (rdByte) begin
      rdData_d = rdHalf_q ? rdp.rdData[7:0] : rdp.rdData[15:8];
      rdHalf_d = ~rdHalf_q;
      rdValid_d = 1'b1;
    end
    // Two-step recompute, well inside the settle time
    case (st_q)
      ST_IDLE: begin
        if (pend_q) begin
          st_d = ST_CUR;
          pend_d = 1'b0;
        end
      end
      ST_CUR: begin
        current_d = trunc16(curProd);
        st_d = ST_PWR;
        busy_d = 1'b1;
      end
      ST_PWR: begin
        power_d = trunc16(pwrProd);
        st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    // Triggers follow the sequencer so a new one beats the pend clear
    // Only setup and scale accept writes
    if (wordDone) begin
      if (ptr == PTR_SETUP) begin
        setup_d = {1'b0, wordVal[14:0]};
      end else if (ptr == PTR_SCALE) begin
        scale_d = wordVal;
        pend_d = 1'b1;
      end
    end
    // New conversion results
    if (shuntStb) begin
      shunt_d = shuntIn;
      pend_d = 1'b1;
    end
    if (railStb) begin
      rail_d = railIn;
      pend_d = 1'b1;
    end
    if (st_d != ST_IDLE || pend_d) begin
      busy_d = 1'b1;
    end
  end

  // Registers; power-on and soft reset share one path
  always_ff @(posedge clk) begin
    if (rst || (ce && softRst)) begin
      setup_q <= SETUP_RST;
      shunt_q <= ZERO16;
      rail_q <= ZERO16;
      power_q <= ZERO16;
      current_q <= ZERO16;
      scale_q <= ZERO16;
      hiByte_q <= 8'h00;
      half_q <= 1'b0;
      rdHalf_q <= 1'b0;
      rdData <= 8'h00;
      rdValid <= 1'b0;
      st_q <= ST_IDLE;
      pend_q <= 1'b0;
      busy <= 1'b0;
    end else if (ce) begin
      setup_q <= setup_d;
      shunt_q <= shunt_d;
      rail_q <= rail_d;
      power_q <= power_d;
      current_q <= current_d;
      scale_q <= scale_d;
      hiByte_q <= hiByte_d;
      half_q <= half_d;
      rdHalf_q <= rdHalf_d;
      rdData <= rdData_d;
      rdValid <= rdValid_d;
      st_q <= st_d;
      pend_q <= pend_d;
      busy <= busy_d;
    end
  end

  // Setup fields out, all from flops
  always_ff @(posedge clk) begin
    if (rst) begin
      railFullScaleSelect <= SETUP_RST[RAIL_FSR_BIT];
      shuntGainSelect <= SETUP_RST[GAIN_HI_BIT:GAIN_LO_BIT];
      convSetup <= SETUP_RST[10:0];
    end else if (ce) begin
      railFullScaleSelect <= setup_q[RAIL_FSR_BIT];
      shuntGainSelect <= setup_q[GAIN_HI_BIT:GAIN_LO_BIT];
      convSetup <= setup_q[10:0];
    end
  end

  // Assertions
  // All are off during reset; each trigger is qualified by the clock enable
  sequence scaleWr_s;
    ce && wordDone && ptr == PTR_SCALE && !rst;
  endsequence
  // Read byte requests, split by which half the toggle selects
  sequence rdHigh_s;
    ce && rdByte && !rdHalf_q && !softRst;
  endsequence
  sequence rdLow_s;
    ce && rdByte && rdHalf_q && !softRst;
  endsequence

  settle_time_a: assert property (@(posedge clk) disable iff (rst)
    scaleWr_s |=> busy ##[1:7] !busy) else $error("recompute not done in time");
  soft_clear_a: assert property (@(posedge clk) disable iff (rst)
    setup_q[SOFT_RST_BIT] == 1'b0) else $error("reset bit did not self-clear");
  soft_reset_a: assert property (@(posedge clk) disable iff (rst)
    (ce && softRst) |=> current_q == ZERO16 && power_q == ZERO16 && scale_q == ZERO16)
    else $error("soft reset left results");
  zero_scale_a: assert property (@(posedge clk) disable iff (rst)
    (scale_q == ZERO16 && st_q == ST_CUR && ce) |=> current_q == ZERO16) else $error("current nonzero");
  ro_shunt_a: assert property (@(posedge clk) disable iff (rst)
    (ce && !shuntStb && !softRst) |=> $stable(shunt_q)) else $error("shunt changed by write");
  setup_write_a: assert property (@(posedge clk) disable iff (rst)
    (ce && wordDone && ptr == PTR_SETUP && !softRst) |=> setup_q == {1'b0, $past(wordVal[14:0])})
    else $error("setup write lost");
  scale_write_a: assert property (@(posedge clk) disable iff (rst)
    scaleWr_s |=> scale_q == $past(wordVal)) else $error("scale write lost");
  cur_calc_a: assert property (@(posedge clk) disable iff (rst)
    (ce && st_q == ST_CUR && !softRst) |=> current_q == trunc16($past(curProd)))
    else $error("current wrong");
  read_pair_a: assert property (@(posedge clk) disable iff (rst)
    (ce && rdByte) |=> rdValid) else $error("read byte missing");
  // Power step uses the fresh current and the shifted rail
  pwr_calc_a: assert property (@(posedge clk) disable iff (rst)
    (ce && st_q == ST_PWR && !softRst) |=> power_q == trunc16($past(pwrProd)))
    else $error("power wrong");
  // Zero current can only give zero power
  pwr_zero_a: assert property (@(posedge clk) disable iff (rst)
    (ce && st_q == ST_PWR && current_q == ZERO16 && !softRst) |=> power_q == ZERO16)
    else $error("power nonzero with zero current");
  // Rail word changes only on its strobe or a reset
  ro_rail_a: assert property (@(posedge clk) disable iff (rst)
    (ce && !railStb && !softRst) |=> $stable(rail_q))
    else $error("rail changed by write");
  // Current and power move only in the recompute states or on a reset
  ro_results_a: assert property (@(posedge clk) disable iff (rst)
    (ce && st_q == ST_IDLE && !softRst) |=> $stable(current_q) && $stable(power_q))
    else $error("result changed outside recompute");
  // A new sample leaves a recompute pending unless a reset lands in the same cycle
  pend_set_a: assert property (@(posedge clk) disable iff (rst)
    (ce && (shuntStb || railStb) && !softRst) |=> pend_q)
    else $error("new sample not queued");
  // Quiet sequencer with no trigger shows not busy
  busy_idle_a: assert property (@(posedge clk) disable iff (rst)
    (ce && st_q == ST_IDLE && !pend_q && !shuntStb && !railStb && !wordDone) |=> !busy)
    else $error("busy without work");
  // Setup word with the top bit set restores defaults
  soft_apply_a: assert property (@(posedge clk) disable iff (rst)
    (ce && wordDone && ptr == PTR_SETUP && wordVal[SOFT_RST_BIT]) |=> setup_q == SETUP_RST && scale_q == ZERO16)
    else $error("soft reset not applied");
  // Front-end fields follow setup one cycle later
  fsr_copy_a: assert property (@(posedge clk) disable iff (rst)
    ce |=> railFullScaleSelect == $past(setup_q[RAIL_FSR_BIT]))
    else $error("range select stale");
  gain_copy_a: assert property (@(posedge clk) disable iff (rst)
    ce |=> shuntGainSelect == $past(setup_q[GAIN_HI_BIT:GAIN_LO_BIT]))
    else $error("gain select stale");
  conv_copy_a: assert property (@(posedge clk) disable iff (rst)
    ce |=> convSetup == $past(setup_q[10:0]))
    else $error("converter setup stale");
  // High byte comes first, then the low byte of the same word
  read_high_a: assert property (@(posedge clk) disable iff (rst)
    rdHigh_s |=> rdData == $past(rdp.rdData[15:8]))
    else $error("high byte wrong");
  read_low_a: assert property (@(posedge clk) disable iff (rst)
    rdLow_s |=> rdData == $past(rdp.rdData[7:0]))
    else $error("low byte wrong");
endmodule // pmr_regs

// ### dv/pmr_host_model.sv
`timescale 1ns/100ps
// Host side of the byte port: whole words only, high byte first
module pmr_host_model
  import pmr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Byte port toward the register bank
  output logic [2:0] ptr,
  output logic wrByte,
  output logic [7:0] wrData,
  output logic wrLast,
  output logic rdByte,
  input wire logic [7:0] rdData,
  input wire logic rdValid
);
  // Idle port at time zero
  initial begin
    ptr = 3'h0;
    wrByte = 1'b0;
    wrData = 8'h00;
    wrLast = 1'b0;
    rdByte = 1'b0;
  end
  // Word write; settle wait so a same-pointer readback is always legal
  task automatic wr(input logic [2:0] p, input logic [15:0] w);
    @(posedge clk) #1;
    ptr = p;
    wrByte = 1'b1;
    wrData = w[15:8];
    @(posedge clk) #1;
    wrData = w[7:0];
    wrLast = 1'b1;
    @(posedge clk) #1;
    wrByte = 1'b0;
    wrLast = 1'b0;
    wrData = ~wrData; // Released byte never keeps its old value
    repeat (SETTLE_CYC) @(posedge clk);
  endtask
  // One byte; a missing valid pulse makes it unknown so the compare fails
  task automatic rdb(output logic [7:0] b);
    @(posedge clk) #1;
    rdByte = 1'b1;
    @(posedge clk) #1;
    rdByte = 1'b0;
    b = rdValid ? rdData : 8'hXX;
  endtask
  // Word read; waits two cycles after a pointer change, one more than the registered read mux needs
  task automatic rd(input logic [2:0] p, output logic [15:0] w);
    @(posedge clk) #1;
    ptr = p;
    repeat (2) @(posedge clk);
    rdb(w[15:8]);
    rdb(w[7:0]);
  endtask
endmodule // pmr_host_model

// ### dv/testbench.sv
`timescale 1ns/100ps
// Self-checking bench for the result register bank
module testbench;
  import pmr_pkg::*;
  // Bench signals
  logic clk, rst, ce, shuntStb, railStb;
  logic [15:0] shuntIn, railIn, w;
  logic [2:0] ptr;
  logic wrByte, wrLast, rdByte, rdValid, busy, railFullScaleSelect;
  logic [7:0] wrData, rdData;
  logic [1:0] shuntGainSelect;
  logic [10:0] convSetup;
  int bad_count = 0;
  int total_checks = 0;
  pmr_regs pmr_regs_inst (.clk, .rst, .ce, .ptr, .wrByte, .wrData, .wrLast, .rdByte, .rdData, .rdValid,
    .shuntStb, .shuntIn, .railStb, .railIn, .railFullScaleSelect, .shuntGainSelect, .convSetup, .busy);
  pmr_host_model pmr_host_model_inst (.clk, .ptr, .wrByte, .wrData, .wrLast, .rdByte, .rdData, .rdValid);
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [2:0] p, input logic [15:0] e);
    pmr_host_model_inst.rd(p, w);
    chk(w, e);
  endtask
  // Converter samples, shunt then rail, inputs scrambled afterwards
  task automatic sample(input logic [15:0] s, input logic [15:0] r);
    @(posedge clk) #1;
    shuntIn = s;
    shuntStb = 1'b1;
    @(posedge clk) #1;
    shuntStb = 1'b0;
    railIn = r;
    railStb = 1'b1;
    @(posedge clk) #1;
    railStb = 1'b0;
    shuntIn = ~s;
    railIn = ~r;
    repeat (SETTLE_CYC) @(posedge clk);
  endtask
  task automatic t_reset();
    rchk(PTR_SETUP, SETUP_RST);
    rchk(PTR_POWER, ZERO16);
    rchk(PTR_CURRENT, ZERO16);
    rchk(PTR_SCALE, ZERO16);
    rchk(3'h6, ZERO16); // Unmapped pointer reads zero
    chk({2'b00, railFullScaleSelect, shuntGainSelect, convSetup}, SETUP_RST);
  endtask
  // Worked example: 20 mV shunt, 11.98 V rail, 1 mA per count
  task automatic t_example();
    sample(16'h07D0, 16'h5D98);
    rchk(PTR_CURRENT, ZERO16);
    pmr_host_model_inst.wr(PTR_SCALE, 16'h5000);
    chk({15'h0000, busy}, ZERO16);
    rchk(PTR_SCALE, 16'h5000);
    rchk(PTR_CURRENT, 16'h2710);
    rchk(PTR_POWER, 16'h1766);
    rchk(PTR_RAIL, 16'h5D98);
    rchk(PTR_SHUNT, 16'h07D0);
  endtask
  // Reverse current keeps its sign; power uses the magnitude
  task automatic t_negative();
    sample(16'hF830, 16'h5D98);
    rchk(PTR_CURRENT, 16'hD8F0);
    rchk(PTR_POWER, 16'h1766);
  endtask
  // Writes to result pointers leave them untouched
  task automatic t_readonly();
    logic [15:0] exp [1:4];
    exp = '{16'hF830, 16'h5D98, 16'h1766, 16'hD8F0};
    for (int p = 1; p <= 4; p++) begin
      pmr_host_model_inst.wr(3'(p), 16'hFFFF);
      rchk(3'(p), exp[p]);
    end
  endtask
  task automatic t_softreset();
    pmr_host_model_inst.wr(PTR_SETUP, 16'h0123);
    rchk(PTR_SETUP, 16'h0123);
    chk({2'b00, railFullScaleSelect, shuntGainSelect, convSetup}, 16'h0123);
    pmr_host_model_inst.wr(PTR_SETUP, 16'h8000);
    rchk(PTR_SETUP, SETUP_RST);
    rchk(PTR_SCALE, ZERO16);
    rchk(PTR_CURRENT, ZERO16);
    rchk(PTR_SHUNT, ZERO16);
    rchk(PTR_POWER, ZERO16);
  endtask
  // Clock enable low: strobes are ignored and nothing moves
  task automatic t_freeze();
    @(posedge clk) #1;
    ce = 1'b0;
    sample(16'h1234, 16'h4321);
    #1 ce = 1'b1;
    rchk(PTR_SHUNT, ZERO16); // Frozen by clock enable
    rchk(PTR_RAIL, ZERO16); // Frozen by clock enable
  endtask
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence after an eight-cycle reset
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    shuntStb = 1'b0;
    railStb = 1'b0;
    shuntIn = 16'h0000;
    railIn = 16'h0000;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    t_reset();
    t_example();
    t_negative();
    t_readonly();
    t_softreset();
    t_freeze();
    test_done();
  end
  // Watchdog, well past the roughly 1800 cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule // testbench
